// File: pkg/msp_map.svh
// msp_map.svh: register offsets, field positions, reset and halt values
// assumes: included by bare name; 16-bit register port, word index addressing
`ifndef MSP_MAP_SVH
`define MSP_MAP_SVH
`define MSP_A_CTRL   4'h0
`define MSP_A_PSEL   4'h1
`define MSP_A_START  4'h2
`define MSP_A_STOP   4'h3
`define MSP_A_STAT   4'h4
`define MSP_A_OUTCTL 4'h5
`define MSP_A_SPLIT  4'h6
`define MSP_A_RL0    4'h8
`define MSP_A_RL1    4'h9
`define MSP_A_RL2    4'hA
`define MSP_A_RL3    4'hB
`define MSP_A_CNT0   4'hC
`define MSP_A_CNT1   4'hD
`define MSP_A_CNT2   4'hE
`define MSP_A_CNT3   4'hF
`define MSP_F_UEN    0
`define MSP_F_OV     0
`define MSP_F_OE     4
`define MSP_F_ROLE   8
`define MSP_F_POL    12
`define MSP_RST_WORD 16'h0000
`define MSP_HALT16   16'hFFFF
`define MSP_HALT8    16'h00FF
`endif

// File: pkg/msp_pkg.sv
// msp_pkg: types and shared helpers of the pwm timer block
// assumes: compiled before every design file
`include "msp_map.svh"
package msp_pkg;
    typedef enum logic {MST_IDLE, MST_RUN} msp_mst_state_t;
    typedef logic [15:0] msp_word_t;

    // lane mask of a channel; a split channel only counts its lower byte
    function automatic msp_word_t lane_mask(input logic split);
        lane_mask = split ? `MSP_HALT8 : `MSP_HALT16;
    endfunction
endpackage

// File: design/msp_prescale.sv
// msp_prescale: count clock tick generator, divide by two to the select
// assumes: en_i low holds the divider cleared (unit powered off)
`timescale 1ns/1ps
`include "msp_map.svh"
module msp_prescale (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       en_i,
    input  wire logic [3:0] sel_i,
    output logic            tick_o
);
    logic [15:0] div_q;
    logic [15:0] low_mask;

    assign low_mask = 16'((17'h0_0001 << sel_i) - 17'h0_0001);
    // no tick at all while the unit is off: that is the stopped clock
    assign tick_o = en_i & ((div_q & low_mask) == low_mask);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            div_q <= `MSP_RST_WORD;
        else if (!en_i)
            div_q <= `MSP_RST_WORD;
        else
            div_q <= div_q + 16'h0001;
    end
endmodule

// File: design/msp_slave.sv
// msp_slave: one-count duty channel retriggered by the master period event
// assumes: tick_i is the count clock pulse, trig_i the gated master event
`timescale 1ns/1ps
`include "msp_map.svh"
module msp_slave (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        clr_i,
    input  wire logic        tick_i,
    input  wire logic        trig_i,
    input  wire logic        en_i,
    input  wire logic        split_i,
    input  wire logic [15:0] reload_i,
    output logic      [15:0] cnt_o,
    output logic             act_o,
    output logic             evt_o
);
    msp_pkg::msp_word_t cnt_q;
    msp_pkg::msp_word_t mask;
    logic               run_q;
    logic               act_q;
    logic               step;

    assign mask  = msp_pkg::lane_mask(split_i);
    assign step  = tick_i & run_q & en_i & ~trig_i;
    assign evt_o = step & (cnt_q == `MSP_RST_WORD);
    assign cnt_o = cnt_q;
    assign act_o = act_q;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt_q <= `MSP_RST_WORD;
        else if (clr_i)
            cnt_q <= `MSP_RST_WORD;
        else if (trig_i)
            cnt_q <= reload_i & mask;
        else if (step)
            cnt_q <= (cnt_q == `MSP_RST_WORD) ? mask : cnt_q - 16'h0001;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            run_q <= 1'b0;
        else if (clr_i)
            run_q <= 1'b0;
        else if (trig_i)
            run_q <= 1'b1;
        else if (evt_o)
            run_q <= 1'b0;
    end

    // a retrigger before zero keeps the level: a long value saturates
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            act_q <= 1'b0;
        else if (clr_i)
            act_q <= 1'b0;
        else if (step)
            act_q <= (cnt_q != `MSP_RST_WORD);
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_active_tick;
        step && cnt_q != `MSP_RST_WORD && !clr_i |=> act_q && cnt_q == $past(cnt_q) - 16'h0001;
    endproperty
    a_active_tick: assert property (p_active_tick) else $error("slave not active after tick");

    property p_zero_halt;
        step && cnt_q == `MSP_RST_WORD && !clr_i |=> !act_q && !run_q && cnt_q == mask;
    endproperty
    a_zero_halt: assert property (p_zero_halt) else $error("slave did not halt at zero");

    property p_halted_hold;
        !run_q && !trig_i && !clr_i |=> $stable(cnt_q) && $stable(act_q);
    endproperty
    a_halted_hold: assert property (p_halted_hold) else $error("halted slave moved");

    c_slave_done: cover property (trig_i ##[1:40] evt_o);
endmodule

// File: design/msp_top.sv
// msp_top: master/slave pwm timer, channel 0 period, channels 1-3 duty
// assumes: single clock; register port with one-cycle read data
`timescale 1ns/1ps
`include "msp_map.svh"
module msp_top #(
    parameter bit SMALL_PKG = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    output logic      [2:0]  pwm_o,
    output logic             master_period_event_o,
    output logic      [2:0]  duty_event_o
);
    logic                    unit_en_q;
    logic [3:0]              psel_q;
    msp_pkg::msp_mst_state_t mst_q;
    logic [3:1]              es_q;
    logic [3:0]              ov_q;
    logic [3:0]              oe_q;
    logic [3:0]              role_q;
    logic [3:0]              pol_q;
    logic [1:0]              split_q;
    msp_pkg::msp_word_t      rl_q [0:3];
    msp_pkg::msp_word_t      cnt0_q;
    msp_pkg::msp_word_t      rdata_q;
    msp_pkg::msp_word_t      rdata_d;
    logic [2:0]              pwm_q;
    logic                    tick;
    logic                    wr_ok;
    logic                    mst_run;
    logic                    mst_wrap;
    logic                    mst_evt;
    logic [3:0]              start_w;
    logic [3:0]              stop_w;
    logic [2:0]              allow;
    logic [2:0]              split_sel;
    logic [2:0]              trig;
    logic [2:0]              s_act;
    logic [2:0]              s_evt;
    msp_pkg::msp_word_t      s_cnt [0:2];

    // every register but the enable itself is locked while powered off
    assign wr_ok    = wr_i & unit_en_q;
    // trigger bits act for one cycle and are never stored
    assign start_w  = (wr_ok && addr_i == `MSP_A_START) ? wdata_i[3:0] : 4'h0;
    assign stop_w   = (wr_ok && addr_i == `MSP_A_STOP) ? wdata_i[3:0] : 4'h0;
    assign mst_run  = (mst_q == msp_pkg::MST_RUN);
    assign mst_wrap = tick & mst_run & (cnt0_q == `MSP_RST_WORD);
    assign mst_evt  = start_w[0] | mst_wrap;
    // large package: only the first duty channel may follow the master
    assign allow    = SMALL_PKG ? 3'b111 : 3'b001;
    assign split_sel = {split_q[1], 1'b0, split_q[0]};

    assign master_period_event_o = mst_evt;
    assign duty_event_o          = s_evt;
    assign pwm_o                 = pwm_q;
    assign rdata_o               = rdata_q;

    msp_prescale u_prescale (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .en_i    (unit_en_q),
        .sel_i   (psel_q),
        .tick_o  (tick)
    );

    genvar k;
    generate
        for (k = 0; k < 3; k++)
        begin : g_slave
            assign trig[k] = mst_evt & allow[k] & role_q[k + 1] & (es_q[k + 1] | start_w[k + 1]);
            msp_slave u_slave (
                .clk_i    (clk_i),
                .rst_b_i  (rst_b_i),
                .clr_i    (~unit_en_q),
                .tick_i   (tick),
                .trig_i   (trig[k]),
                .en_i     (es_q[k + 1]),
                .split_i  (split_sel[k]),
                .reload_i (rl_q[k + 1]),
                .cnt_o    (s_cnt[k]),
                .act_o    (s_act[k]),
                .evt_o    (s_evt[k])
            );
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            unit_en_q <= 1'b0;
        else if (wr_i && addr_i == `MSP_A_CTRL)
            unit_en_q <= wdata_i[`MSP_F_UEN];
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            psel_q <= 4'h0;
        else if (!unit_en_q)
            psel_q <= 4'h0;
        else if (wr_ok && addr_i == `MSP_A_PSEL)
            psel_q <= wdata_i[3:0];
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ov_q    <= 4'h0;
            oe_q    <= 4'h0;
            role_q  <= 4'h0;
            pol_q   <= 4'h0;
            split_q <= 2'b00;
        end
        else if (!unit_en_q)
        begin
            ov_q    <= 4'h0;
            oe_q    <= 4'h0;
            role_q  <= 4'h0;
            pol_q   <= 4'h0;
            split_q <= 2'b00;
        end
        else if (wr_ok && addr_i == `MSP_A_OUTCTL)
        begin
            ov_q   <= wdata_i[`MSP_F_OV +: 4];
            oe_q   <= wdata_i[`MSP_F_OE +: 4];
            role_q <= wdata_i[`MSP_F_ROLE +: 4];
            pol_q  <= wdata_i[`MSP_F_POL +: 4];
        end
        else if (wr_ok && addr_i == `MSP_A_SPLIT)
            split_q <= wdata_i[1:0];
    end

    // reloads are only copied at the master event, so writes never glitch
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < 4; i++)
                rl_q[i] <= `MSP_RST_WORD;
        end
        else if (!unit_en_q)
        begin
            for (int i = 0; i < 4; i++)
                rl_q[i] <= `MSP_RST_WORD;
        end
        else if (wr_ok && addr_i[3:2] == 2'b10)
            rl_q[addr_i[1:0]] <= wdata_i;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            mst_q <= msp_pkg::MST_IDLE;
        else if (!unit_en_q)
            mst_q <= msp_pkg::MST_IDLE;
        else
        begin
            case (mst_q)
                msp_pkg::MST_IDLE:
                    if (start_w[0])
                        mst_q <= msp_pkg::MST_RUN;
                msp_pkg::MST_RUN:
                    if (stop_w[0] && !start_w[0])
                        mst_q <= msp_pkg::MST_IDLE;
                default:
                    mst_q <= msp_pkg::MST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            es_q <= 3'b000;
        else if (!unit_en_q)
            es_q <= 3'b000;
        else
            // start beats stop in one write, as on the master
            es_q <= (es_q & ~stop_w[3:1]) | start_w[3:1];
    end

    // stop leaves the counter where it was: no reload, no clear
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt0_q <= `MSP_RST_WORD;
        else if (!unit_en_q)
            cnt0_q <= `MSP_RST_WORD;
        else if (start_w[0])
            cnt0_q <= rl_q[0];
        else if (mst_wrap)
            cnt0_q <= rl_q[0];
        else if (tick && mst_run)
            cnt0_q <= cnt0_q - 16'h0001;
    end

    // disabled output follows the written value; polarity flips both phases
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pwm_q <= 3'b000;
        else if (!unit_en_q)
            pwm_q <= 3'b000;
        else
        begin
            for (int i = 0; i < 3; i++)
                pwm_q[i] <= oe_q[i + 1] ? (s_act[i] ^ pol_q[i + 1]) : ov_q[i + 1];
        end
    end

    always_comb
    begin
        rdata_d = `MSP_RST_WORD;
        case (addr_i)
            `MSP_A_CTRL:   rdata_d = {15'h0000, unit_en_q};
            `MSP_A_PSEL:   rdata_d = {12'h000, psel_q};
            `MSP_A_STAT:   rdata_d = {12'h000, es_q, mst_run};
            `MSP_A_OUTCTL: rdata_d = {pol_q, role_q, oe_q, ov_q};
            `MSP_A_SPLIT:  rdata_d = {14'h0000, split_q};
            `MSP_A_RL0:    rdata_d = rl_q[0];
            `MSP_A_RL1:    rdata_d = rl_q[1];
            `MSP_A_RL2:    rdata_d = rl_q[2];
            `MSP_A_RL3:    rdata_d = rl_q[3];
            `MSP_A_CNT0:   rdata_d = cnt0_q;
            `MSP_A_CNT1:   rdata_d = s_cnt[0];
            `MSP_A_CNT2:   rdata_d = s_cnt[1];
            `MSP_A_CNT3:   rdata_d = s_cnt[2];
            default:       rdata_d = `MSP_RST_WORD;
        endcase
        if (!unit_en_q && addr_i != `MSP_A_CTRL)
            rdata_d = `MSP_RST_WORD;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_q <= `MSP_RST_WORD;
        else
            rdata_q <= rd_i ? rdata_d : `MSP_RST_WORD;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_start_load;
        start_w[0] |=> mst_run && cnt0_q == $past(rl_q[0]);
    endproperty
    a_start_load: assert property (p_start_load) else $error("start did not load master");

    property p_count_down;
        tick && mst_run && cnt0_q != `MSP_RST_WORD && !start_w[0] && unit_en_q
            && !(wr_i && addr_i == `MSP_A_CTRL) |=> cnt0_q == $past(cnt0_q) - 16'h0001;
    endproperty
    a_count_down: assert property (p_count_down) else $error("master did not count down");

    property p_wrap_reload;
        mst_wrap && !start_w[0] && !(wr_i && addr_i == `MSP_A_CTRL)
            |-> master_period_event_o ##1 cnt0_q == $past(rl_q[0]);
    endproperty
    a_wrap_reload: assert property (p_wrap_reload) else $error("master did not reload at zero");

    property p_stop_freeze;
        unit_en_q && !mst_run && !start_w[0] && !(wr_i && addr_i == `MSP_A_CTRL)
            |=> $stable(cnt0_q) && !mst_run;
    endproperty
    a_stop_freeze: assert property (p_stop_freeze) else $error("stopped master moved");

    property p_slave1_load;
        trig[0] && !split_q[0] && unit_en_q |=> s_cnt[0] == $past(rl_q[1]);
    endproperty
    a_slave1_load: assert property (p_slave1_load) else $error("slave 1 not loaded");

    property p_slave2_load;
        trig[1] && unit_en_q |=> s_cnt[1] == $past(rl_q[2]);
    endproperty
    a_slave2_load: assert property (p_slave2_load) else $error("slave 2 not loaded");

    property p_split_low;
        trig[0] && split_q[0] && unit_en_q |=> s_cnt[0][15:8] == 8'h00;
    endproperty
    a_split_low: assert property (p_split_low) else $error("split slave used upper byte");

    property p_direct_pin;
        unit_en_q && !oe_q[1] |=> !unit_en_q || pwm_o[0] == $past(ov_q[1]);
    endproperty
    a_direct_pin: assert property (p_direct_pin) else $error("pin ignored output value");

    property p_polarity;
        unit_en_q && oe_q[1] |=> !unit_en_q || pwm_o[0] == ($past(s_act[0]) ^ $past(pol_q[1]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("pin polarity wrong");

    property p_off_clear;
        !unit_en_q |=> !unit_en_q || (es_q == 3'b000 && cnt0_q == `MSP_RST_WORD && !mst_run);
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("registers kept while off");

    property p_refuse;
        !unit_en_q && wr_i && addr_i == `MSP_A_RL0 |=> rl_q[0] == `MSP_RST_WORD;
    endproperty
    a_refuse: assert property (p_refuse) else $error("write accepted while off");

    property p_trigger_zero;
        rd_i && (addr_i == `MSP_A_START || addr_i == `MSP_A_STOP) |=> rdata_o == `MSP_RST_WORD;
    endproperty
    a_trigger_zero: assert property (p_trigger_zero) else $error("trigger bits read back set");

    c_period: cover property (mst_wrap ##[1:60] mst_wrap);
    c_duty: cover property (trig[0] ##[1:60] s_evt[0]);
    c_stop_hold: cover property (mst_run && pwm_o[0] ##1 !mst_run);
endmodule

// File: test/master_slave_pwm_timer_bench.sv
// master_slave_pwm_timer_bench: self-checking bench for msp_top
// assumes: msp_pkg and msp_map.svh visible; 250 MHz clock, one-cycle read data
`timescale 1ns/1ps
`include "msp_map.svh"
module master_slave_pwm_timer_bench;
    typedef struct {
        logic [3:0]  psel;
        logic [15:0] rl [4];
        logic [2:0]  pol;
        int          per;
        int          hi [3];
        int          ev [3];
    } msp_row_t;

    logic        clk_i;
    logic        rst_b_i;
    logic [3:0]  addr_i;
    logic [15:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [15:0] rdata_o;
    logic [2:0]  pwm_o;
    logic        master_period_event_o;
    logic [2:0]  duty_event_o;
    int          miscompares;
    int          n_tests;
    int          m_per;
    int          m_hi [3];
    int          m_ev [3];
    msp_row_t    rows [4];

    msp_top #(.SMALL_PKG(1'b1)) uut (
        .clk_i                 (clk_i),
        .rst_b_i               (rst_b_i),
        .addr_i                (addr_i),
        .wdata_i               (wdata_i),
        .wr_i                  (wr_i),
        .rd_i                  (rd_i),
        .rdata_o               (rdata_o),
        .pwm_o                 (pwm_o),
        .master_period_event_o (master_period_event_o),
        .duty_event_o          (duty_event_o)
    );

    always #2 clk_i = ~clk_i;

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_num(input int got, input int exp, input string msg);
        n_tests++;
        if (got != exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk_word(rdata_o, exp, "register read");
    endtask

    // sel 0: master event, 1: first duty event; bounded so a dead timer cannot hang
    task automatic wait_evt(input int sel);
        int n;
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (((sel == 0) ? master_period_event_o : duty_event_o[0]) !== 1'b1 && n < 3000);
        if (n >= 3000)
            chk_num(n, 0, "event never came");
    endtask

    // one full period from a master event to the next, pins and events tallied
    task automatic meas;
        wait_evt(0);
        m_per = 0;
        m_hi  = '{0, 0, 0};
        m_ev  = '{0, 0, 0};
        do
        begin
            for (int i = 0; i < 3; i++)
            begin
                m_hi[i] += (pwm_o[i] === 1'b1) ? 1 : 0;
                m_ev[i] += (duty_event_o[i] === 1'b1) ? 1 : 0;
            end
            m_per++;
            @(negedge clk_i);
        end
        while (master_period_event_o !== 1'b1 && m_per < 3000);
    endtask

    // power cycle first so every row starts from reset values
    task automatic cfg(input logic [3:0] ps, input logic [15:0] r0, input logic [15:0] r1,
                       input logic [15:0] r2, input logic [15:0] r3, input logic [2:0] pol,
                       input logic [15:0] split);
        wr(`MSP_A_CTRL, 16'h0000);
        wr(`MSP_A_CTRL, 16'h0001);
        wr(`MSP_A_PSEL, {12'h000, ps});
        wr(`MSP_A_SPLIT, split);
        wr(`MSP_A_RL0, r0);
        wr(`MSP_A_RL1, r1);
        wr(`MSP_A_RL2, r2);
        wr(`MSP_A_RL3, r3);
        wr(`MSP_A_OUTCTL, {pol, 1'b0, 4'hE, 4'hE, 4'h0});
        wr(`MSP_A_START, 16'h000F);
    endtask

    initial
    begin
        #(4 * 30000);
        miscompares++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        complete_run();
    end

    initial
    begin
        int          chg;
        int          mev;
        logic [2:0]  p0;
        clk_i       = 1'b0;
        rst_b_i     = 1'b0;
        addr_i      = 4'h0;
        wdata_i     = 16'h0000;
        wr_i        = 1'b0;
        rd_i        = 1'b0;
        miscompares = 0;
        n_tests     = 0;
        rows[0] = '{4'h0, '{16'h0007, 16'h0003, 16'h0000, 16'h0009}, 3'b000, 8, '{3, 0, 8}, '{1, 1, 0}};
        rows[1] = '{4'h0, '{16'h0005, 16'h0002, 16'h0006, 16'h0001}, 3'b101, 6, '{4, 6, 5}, '{1, 0, 1}};
        rows[2] = '{4'h1, '{16'h0004, 16'h0002, 16'h0003, 16'h0014}, 3'b010, 10, '{4, 4, 10}, '{1, 1, 0}};
        rows[3] = '{4'h2, '{16'h0002, 16'h0001, 16'h0000, 16'h0001}, 3'b000, 12, '{4, 0, 4}, '{1, 1, 1}};
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // writes while powered off must be dropped
        wr(`MSP_A_RL0, 16'h1234);
        rd_chk(`MSP_A_CTRL, 16'h0000);
        wr(`MSP_A_CTRL, 16'h0001);
        rd_chk(`MSP_A_CTRL, 16'h0001);
        rd_chk(`MSP_A_RL0, 16'h0000);
        rd_chk(4'h7, 16'h0000);
        foreach (rows[k])
        begin
            cfg(rows[k].psel, rows[k].rl[0], rows[k].rl[1], rows[k].rl[2], rows[k].rl[3], rows[k].pol, 16'h0000);
            meas();
            chk_num(m_per, rows[k].per, "period");
            for (int i = 0; i < 3; i++)
            begin
                chk_num(m_hi[i], rows[k].hi[i], "pin high cycles");
                chk_num(m_ev[i], rows[k].ev[i], "duty events");
            end
        end
        cfg(4'h0, 16'h0007, 16'h0003, 16'h0000, 16'h0009, 3'b000, 16'h0000);
        rd_chk(`MSP_A_START, 16'h0000);
        rd_chk(`MSP_A_STAT, 16'h000F);
        wait_evt(1);
        rd_chk(`MSP_A_CNT1, 16'hFFFF);
        // stop: status clears, pins freeze and no master event follows
        wr(`MSP_A_STOP, 16'h000F);
        rd_chk(`MSP_A_STAT, 16'h0000);
        repeat (3) @(negedge clk_i);
        p0  = pwm_o;
        chg = 0;
        mev = 0;
        repeat (40)
        begin
            @(negedge clk_i);
            chg += (pwm_o !== p0) ? 1 : 0;
            mev += (master_period_event_o === 1'b1) ? 1 : 0;
        end
        chk_num(chg, 0, "pin moved after stop");
        chk_num(mev, 0, "event after stop");
        // output enable off: pin follows the written value
        wr(`MSP_A_OUTCTL, 16'h0E02);
        repeat (3) @(negedge clk_i);
        chk_word({15'h0000, pwm_o[0]}, 16'h0001, "pin follows value bit");
        wr(`MSP_A_OUTCTL, 16'h0E00);
        repeat (3) @(negedge clk_i);
        chk_word({15'h0000, pwm_o[0]}, 16'h0000, "pin follows value bit");
        // split channel 1: only the lower byte counts
        cfg(4'h0, 16'h0009, 16'h0503, 16'h0000, 16'h0000, 3'b000, 16'h0001);
        meas();
        chk_num(m_hi[0], 3, "split duty");
        wait_evt(1);
        rd_chk(`MSP_A_CNT1, 16'h00FF);
        // power-off returns every register and pin to reset
        wr(`MSP_A_CTRL, 16'h0000);
        repeat (3) @(negedge clk_i);
        chk_word({13'h0000, pwm_o}, 16'h0000, "pins after power off");
        wr(`MSP_A_CTRL, 16'h0001);
        rd_chk(`MSP_A_RL0, 16'h0000);
        rd_chk(`MSP_A_PSEL, 16'h0000);
        rd_chk(`MSP_A_STAT, 16'h0000);
        complete_run();
    end
endmodule
